// File: pxb_pkg.sv
// package for the priority pin crossbar: signal order, config bit positions,
// reset values and the carrier structs shared by the design.
// assumes a single system clock and synchronous reset in the user.
`default_nettype none
package pxb_pkg;
  // -------------------------------------------------------------------------
  // sizes
  // -------------------------------------------------------------------------
  localparam int NUM_SIG = 32;
  localparam int NUM_PIN = 32;
  localparam int PINS_SMALL = 24;
  localparam int SIG_W = 5;
  localparam int CNT_MAX = 6;
  localparam int NUM_PORT = 8;
  // -------------------------------------------------------------------------
  // peripheral signals in priority order, index 0 ranks highest
  // -------------------------------------------------------------------------
  localparam int SIG_TX0 = 0;
  localparam int SIG_RX0 = 1;
  localparam int SIG_SCK = 2;
  localparam int SIG_MISO = 3;
  localparam int SIG_MOSI = 4;
  localparam int SIG_NSS = 5;
  localparam int SIG_SDA = 6;
  localparam int SIG_SCL = 7;
  localparam int SIG_TX1 = 8;
  localparam int SIG_RX1 = 9;
  localparam int SIG_CAPTURE_COMPARE_OUTPUT = 10;
  localparam int SIG_ECI = 16;
  localparam int SIG_CP0 = 17;
  localparam int SIG_CP1 = 18;
  localparam int SIG_CP2 = 19;
  localparam int SIG_T0 = 20;
  localparam int SIG_INT0 = 21;
  localparam int SIG_T1 = 22;
  localparam int SIG_INT1 = 23;
  localparam int SIG_T2 = 24;
  localparam int SIG_T2EX = 25;
  localparam int SIG_T3 = 26;
  localparam int SIG_T3EX = 27;
  localparam int SIG_T4 = 28;
  localparam int SIG_T4EX = 29;
  localparam int SIG_SYSCLK = 30;
  localparam int SIG_CNV2 = 31;
  // -------------------------------------------------------------------------
  // routing enable bit positions
  // -------------------------------------------------------------------------
  localparam int A_TWOWIRE = 0;
  localparam int A_SPI = 1;
  localparam int A_SERIAL0 = 2;
  localparam int A_CNT_LSB = 3;
  localparam int A_CNT_MSB = 5;
  localparam int A_EXTCLK = 6;
  localparam int A_CMP0 = 7;
  localparam int B_CMP1 = 0;
  localparam int B_T0 = 1;
  localparam int B_INT0 = 2;
  localparam int B_T1 = 3;
  localparam int B_INT1 = 4;
  localparam int B_T2 = 5;
  localparam int B_T2EX = 6;
  localparam int B_SYSCLK = 7;
  localparam int C_SERIAL1 = 2;
  localparam int C_T4 = 3;
  localparam int C_T4EX = 4;
  localparam int D_T3 = 0;
  localparam int D_T3EX = 1;
  localparam int D_CNV2 = 2;
  localparam int D_CMP2 = 3;
  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [7:0] PORT_RST = 8'hff;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] WORD_ONES = 32'hffff_ffff;
  // -------------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] d;
    logic [7:0] c;
    logic [7:0] b;
    logic [7:0] a;
  } pxb_cfg_t;
  typedef struct packed {
    logic en;
    logic [2:0] port;
    logic [7:0] data;
  } pxb_byte_wr_t;
  typedef struct packed {
    logic en;
    logic [4:0] idx;
    logic val;
  } pxb_bit_wr_t;
endpackage : pxb_pkg
`default_nettype wire

// File: pxb_crossbar.sv
// priority pin crossbar for ports 0..3 plus byte-only gpio for ports 4..7.
// assumes peripherals on the same clock; pins arrive asynchronously.
//
// What this block does
// - allocate pins upward from first pin, as needed
// - fixed priority, serial0 highest, converter2 start lowest
// - only enabled peripherals get pins
// - serial0 enabled takes pins 0 and 1 unless either is analog
// - disabled signals reach no pin, use none
// - port read returns actual pin level, but analog pins and upper ports in small package read low
// - lower ports writable by byte and bit
// - upper ports byte-only gpio, no crossbar
// - spi 3-wire mode drops slave select pin
// - twowire, spi, serial1 enable bit positions
// - capture output count field, extclk enable
// - comparator enable bits across config registers
// - unallocated lower pins stay gpio
// - analog pins are skipped by allocation
// - signals are allocated one at a time; a peripheral splits if pins run out
`timescale 1ns/100ps
`default_nettype none
module pxb_crossbar (
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // configuration
  input wire pxb_pkg::pxb_cfg_t cfg_i,
  input wire logic spi_three_wire_i,
  input wire logic large_pkg_i,
  input wire logic [31:0] analog_skip_i,
  // port data access
  input wire pxb_pkg::pxb_byte_wr_t byte_wr_i,
  input wire pxb_pkg::pxb_bit_wr_t bit_wr_i,
  output logic [31:0] lower_rd_o,
  output logic [31:0] upper_rd_o,
  // peripheral side
  input wire logic [31:0] periph_out_i,
  input wire logic [31:0] periph_oe_i,
  output logic [31:0] periph_in_o,
  // lower pins
  input wire logic [31:0] pin_in_i,
  output logic [31:0] pin_out_o,
  output logic [31:0] pin_oe_o,
  // upper pins
  input wire logic [31:0] upin_in_i,
  output logic [31:0] upin_out_o,
  output logic [31:0] upin_oe_o
);
  // -------------------------------------------------------------------------
  // enables per signal
  // -------------------------------------------------------------------------
  logic [31:0] sig_en;
  logic [2:0] cnt_field;
  always_comb
  begin
    sig_en = pxb_pkg::WORD_ZERO;
    cnt_field = cfg_i.a[pxb_pkg::A_CNT_MSB:pxb_pkg::A_CNT_LSB];
    sig_en[pxb_pkg::SIG_TX0] = cfg_i.a[pxb_pkg::A_SERIAL0];
    sig_en[pxb_pkg::SIG_RX0] = cfg_i.a[pxb_pkg::A_SERIAL0];
    sig_en[pxb_pkg::SIG_SCK] = cfg_i.a[pxb_pkg::A_SPI];
    sig_en[pxb_pkg::SIG_MISO] = cfg_i.a[pxb_pkg::A_SPI];
    sig_en[pxb_pkg::SIG_MOSI] = cfg_i.a[pxb_pkg::A_SPI];
    sig_en[pxb_pkg::SIG_NSS] = cfg_i.a[pxb_pkg::A_SPI] & ~spi_three_wire_i;
    sig_en[pxb_pkg::SIG_SDA] = cfg_i.a[pxb_pkg::A_TWOWIRE];
    sig_en[pxb_pkg::SIG_SCL] = cfg_i.a[pxb_pkg::A_TWOWIRE];
    sig_en[pxb_pkg::SIG_TX1] = cfg_i.c[pxb_pkg::C_SERIAL1];
    sig_en[pxb_pkg::SIG_RX1] = cfg_i.c[pxb_pkg::C_SERIAL1];
    for (int k = 0; k < pxb_pkg::CNT_MAX; k++)
    begin
      // codes above six saturate at all six outputs
      sig_en[pxb_pkg::SIG_CAPTURE_COMPARE_OUTPUT + k] = (int'(cnt_field) > k);
    end
    sig_en[pxb_pkg::SIG_ECI] = cfg_i.a[pxb_pkg::A_EXTCLK];
    sig_en[pxb_pkg::SIG_CP0] = cfg_i.a[pxb_pkg::A_CMP0];
    sig_en[pxb_pkg::SIG_CP1] = cfg_i.b[pxb_pkg::B_CMP1];
    sig_en[pxb_pkg::SIG_CP2] = cfg_i.d[pxb_pkg::D_CMP2];
    sig_en[pxb_pkg::SIG_T0] = cfg_i.b[pxb_pkg::B_T0];
    sig_en[pxb_pkg::SIG_INT0] = cfg_i.b[pxb_pkg::B_INT0];
    sig_en[pxb_pkg::SIG_T1] = cfg_i.b[pxb_pkg::B_T1];
    sig_en[pxb_pkg::SIG_INT1] = cfg_i.b[pxb_pkg::B_INT1];
    sig_en[pxb_pkg::SIG_T2] = cfg_i.b[pxb_pkg::B_T2];
    sig_en[pxb_pkg::SIG_T2EX] = cfg_i.b[pxb_pkg::B_T2EX];
    sig_en[pxb_pkg::SIG_T3] = cfg_i.d[pxb_pkg::D_T3];
    sig_en[pxb_pkg::SIG_T3EX] = cfg_i.d[pxb_pkg::D_T3EX];
    sig_en[pxb_pkg::SIG_T4] = cfg_i.c[pxb_pkg::C_T4];
    sig_en[pxb_pkg::SIG_T4EX] = cfg_i.c[pxb_pkg::C_T4EX];
    sig_en[pxb_pkg::SIG_SYSCLK] = cfg_i.b[pxb_pkg::B_SYSCLK];
    sig_en[pxb_pkg::SIG_CNV2] = cfg_i.d[pxb_pkg::D_CNV2];
  end
  // -------------------------------------------------------------------------
  // pin input synchronisers
  // -------------------------------------------------------------------------
  logic [31:0] pin_meta_r;
  logic [31:0] pin_sync_r;
  logic [31:0] upin_meta_r;
  logic [31:0] upin_sync_r;
  // -------------------------------------------------------------------------
  // allocation, purely combinational from current settings
  // -------------------------------------------------------------------------
  logic [31:0] pin_usable;
  logic [31:0] sel_valid;
  logic [pxb_pkg::SIG_W-1:0] sel_idx [pxb_pkg::NUM_PIN];
  logic [31:0] sig_used;
  always_comb
  begin
    int next_pin;
    logic found;
    next_pin = 0;
    found = 1'b0;
    sel_valid = pxb_pkg::WORD_ZERO;
    sig_used = pxb_pkg::WORD_ZERO;
    for (int p = 0; p < pxb_pkg::NUM_PIN; p++)
    begin
      sel_idx[p] = '0;
      // small package ends at port 2; analog pins are passed over
      pin_usable[p] = ~analog_skip_i[p] & (large_pkg_i | (p < pxb_pkg::PINS_SMALL));
    end
    // walk in priority order; each enabled signal takes the next usable pin
    for (int s = 0; s < pxb_pkg::NUM_SIG; s++)
    begin
      if (sig_en[s])
      begin
        found = 1'b0;
        for (int p = 0; p < pxb_pkg::NUM_PIN; p++)
        begin
          if (!found && p >= next_pin && pin_usable[p])
          begin
            found = 1'b1;
            sel_valid[p] = 1'b1;
            sel_idx[p] = s[pxb_pkg::SIG_W-1:0];
            sig_used[s] = 1'b1;
            next_pin = p + 1;
          end
        end
      end
    end
  end
  // -------------------------------------------------------------------------
  // port data latches
  // -------------------------------------------------------------------------
  logic [31:0] lat_r;
  logic [31:0] lat_nxt;
  logic [31:0] ulat_r;
  logic [31:0] ulat_nxt;
  always_comb
  begin
    lat_nxt = lat_r;
    ulat_nxt = ulat_r;
    if (byte_wr_i.en)
    begin
      // upper ports take byte writes only
      if (byte_wr_i.port[2])
      begin
        ulat_nxt[8*byte_wr_i.port[1:0] +: 8] = byte_wr_i.data;
      end
      else
      begin
        lat_nxt[8*byte_wr_i.port[1:0] +: 8] = byte_wr_i.data;
      end
    end
    // bit write after byte write: the bit wins if both hit one pin
    if (bit_wr_i.en)
    begin
      lat_nxt[bit_wr_i.idx] = bit_wr_i.val;
    end
  end
  // -------------------------------------------------------------------------
  // pin drive and read back
  // -------------------------------------------------------------------------
  logic [31:0] pout_nxt;
  logic [31:0] poe_nxt;
  logic [31:0] pin_nxt;
  logic [31:0] lrd_nxt;
  logic [31:0] urd_nxt;
  logic [31:0] upr_mask;
  always_comb
  begin
    pin_nxt = pxb_pkg::WORD_ONES;
    upr_mask = large_pkg_i ? pxb_pkg::WORD_ONES : pxb_pkg::WORD_ZERO;
    for (int p = 0; p < pxb_pkg::NUM_PIN; p++)
    begin
      if (sel_valid[p])
      begin
        pout_nxt[p] = periph_out_i[sel_idx[p]];
        poe_nxt[p] = periph_oe_i[sel_idx[p]];
        pin_nxt[sel_idx[p]] = pin_sync_r[p];
      end
      else
      begin
        // gpio is open-drain: drive only a low
        pout_nxt[p] = lat_r[p];
        poe_nxt[p] = ~lat_r[p] & pin_usable[p];
      end
    end
    // analog pins have no digital input path and read low
    lrd_nxt = pin_sync_r & ~analog_skip_i;
    urd_nxt = upin_sync_r & upr_mask;
  end
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pin_meta_r <= pxb_pkg::WORD_ONES;
      pin_sync_r <= pxb_pkg::WORD_ONES;
      upin_meta_r <= pxb_pkg::WORD_ONES;
      upin_sync_r <= pxb_pkg::WORD_ONES;
      lat_r <= {4{pxb_pkg::PORT_RST}};
      ulat_r <= {4{pxb_pkg::PORT_RST}};
      pin_out_o <= pxb_pkg::WORD_ONES;
      pin_oe_o <= pxb_pkg::WORD_ZERO;
      upin_out_o <= pxb_pkg::WORD_ONES;
      upin_oe_o <= pxb_pkg::WORD_ZERO;
      periph_in_o <= pxb_pkg::WORD_ONES;
      lower_rd_o <= pxb_pkg::WORD_ZERO;
      upper_rd_o <= pxb_pkg::WORD_ZERO;
    end
    else if (ce_i)
    begin
      pin_meta_r <= pin_in_i;
      pin_sync_r <= pin_meta_r;
      upin_meta_r <= upin_in_i;
      upin_sync_r <= upin_meta_r;
      lat_r <= lat_nxt;
      ulat_r <= ulat_nxt;
      pin_out_o <= pout_nxt;
      pin_oe_o <= poe_nxt;
      upin_out_o <= ulat_r;
      upin_oe_o <= ~ulat_r & upr_mask;
      periph_in_o <= pin_nxt;
      lower_rd_o <= lrd_nxt;
      upper_rd_o <= urd_nxt;
    end
  end
  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  logic dup_pin;
  always_comb
  begin
    dup_pin = 1'b0;
    for (int p = 0; p < pxb_pkg::NUM_PIN; p++)
    begin
      for (int q = 0; q < p; q++)
      begin
        if (sel_valid[p] && sel_valid[q] && sel_idx[p] == sel_idx[q])
        begin
          dup_pin = 1'b1;
        end
      end
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_serial0_fixed;
    cfg_i.a[pxb_pkg::A_SERIAL0] && !analog_skip_i[0] && !analog_skip_i[1]
      |-> sel_valid[0] && sel_idx[0] == pxb_pkg::SIG_W'(pxb_pkg::SIG_TX0)
      && sel_valid[1] && sel_idx[1] == pxb_pkg::SIG_W'(pxb_pkg::SIG_RX0);
  endproperty
  a_serial0_fixed: assert property (p_serial0_fixed) else $error("serial0 not on pins 0,1");
  property p_only_enabled;
    sel_valid[2] |-> sig_en[sel_idx[2]];
  endproperty
  a_only_enabled: assert property (p_only_enabled) else $error("disabled signal on pin");
  property p_skip_analog;
    analog_skip_i[3] |-> !sel_valid[3];
  endproperty
  a_skip_analog: assert property (p_skip_analog) else $error("analog pin allocated");
  property p_three_wire;
    spi_three_wire_i |-> !sig_used[pxb_pkg::SIG_NSS];
  endproperty
  a_three_wire: assert property (p_three_wire) else $error("slave select in 3-wire");
  property p_unique;
    !dup_pin;
  endproperty
  a_unique: assert property (p_unique) else $error("signal on two pins");
  property p_pair;
    !large_pkg_i |-> sig_used[pxb_pkg::SIG_TX1] == sig_used[pxb_pkg::SIG_RX1]
      || !sig_en[pxb_pkg::SIG_TX1];
  endproperty
  a_pair: assert property (p_pair) else $error("serial1 pins split");
  property p_gpio_drive;
    ce_i && !sel_valid[5] && pin_usable[5] |=> pin_oe_o[5] == !$past(lat_r[5]);
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) else $error("gpio drive wrong");
  property p_read_pin;
    // both sync stages must have run, and the analog mask is applied at the last stage
    ce_i ##1 ce_i ##1 (ce_i && !analog_skip_i[4]) |=> lower_rd_o[4] == $past(pin_in_i[4], 3);
  endproperty
  a_read_pin: assert property (p_read_pin) else $error("port read not pin level");
  property p_bit_write;
    ce_i && bit_wr_i.en |=> lat_r[$past(bit_wr_i.idx)] == $past(bit_wr_i.val);
  endproperty
  a_bit_write: assert property (p_bit_write) else $error("bit write lost");
  property p_first_pin;
    sig_en[pxb_pkg::SIG_TX0] && !analog_skip_i[0] |-> sel_valid[0];
  endproperty
  a_first_pin: assert property (p_first_pin) else $error("allocation not from pin 0");
endmodule : pxb_crossbar
`default_nettype wire

// File: pxb_pin_model.sv
// far-side model of the pads: resolves each pin from chip drive, an
// external driver and the weak pull-up. assumes open-drain style sharing.
`timescale 1ns/100ps
`default_nettype none
module pxb_pin_model (
  // chip side
  input wire logic [31:0] drv_out_i,
  input wire logic [31:0] drv_oe_i,
  // board side
  input wire logic [31:0] ext_val_i,
  input wire logic [31:0] ext_en_i,
  // resolved level
  output logic [31:0] pin_o
);
  // -------------------------------------------------------------------------
  // resolution
  // -------------------------------------------------------------------------
  // chip drive wins; released lines float up, never keep a stale level
  assign pin_o = (drv_oe_i & drv_out_i) | (~drv_oe_i & ext_en_i & ext_val_i) |
                 (~drv_oe_i & ~ext_en_i);
endmodule : pxb_pin_model
`default_nettype wire

// File: tb.sv
// self-checking bench for the priority pin crossbar.
// assumes pxb_pkg and pxb_crossbar compiled first; pads come from pxb_pin_model.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  pxb_pkg::pxb_cfg_t cfg = '0;
  pxb_pkg::pxb_byte_wr_t bw = '0;
  pxb_pkg::pxb_bit_wr_t bitw = '0;
  logic tw = 1'b0;
  logic lg = 1'b0;
  logic ce = 1'b1;
  logic [31:0] an = 32'h0, pout = 32'h0, poe = 32'h0, xv = 32'h0, xe = 32'h0;
  logic [31:0] uxv = 32'h0, uxe = 32'h0, pin_in, upin_in, lower_rd, upper_rd, periph_in;
  logic [31:0] pin_out, pin_oe, upin_out, upin_oe;
  logic [31:0] lat = 32'hffff_ffff, ulat = 32'hffff_ffff;
  logic [15:0] lf = 16'h98a5;
  int failures = 0, cmp_count = 0, cyc = 0;
  always #5 clock_i = ~clock_i;
  pxb_crossbar u_dut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce), .cfg_i(cfg),
    .spi_three_wire_i(tw), .large_pkg_i(lg), .analog_skip_i(an), .byte_wr_i(bw),
    .bit_wr_i(bitw), .lower_rd_o(lower_rd), .upper_rd_o(upper_rd), .periph_out_i(pout),
    .periph_oe_i(poe), .periph_in_o(periph_in), .pin_in_i(pin_in), .pin_out_o(pin_out),
    .pin_oe_o(pin_oe), .upin_in_i(upin_in), .upin_out_o(upin_out), .upin_oe_o(upin_oe));
  pxb_pin_model u_low (.drv_out_i(pin_out), .drv_oe_i(pin_oe), .ext_val_i(xv),
    .ext_en_i(xe), .pin_o(pin_in));
  pxb_pin_model u_up (.drv_out_i(upin_out), .drv_oe_i(upin_oe), .ext_val_i(uxv),
    .ext_en_i(uxe), .pin_o(upin_in));
  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 32; i++)
    begin
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      v = {v[30:0], lf[0]};
    end
    return v;
  endfunction : rnd
  function automatic logic sig_en(int s);
    logic [2:0] n;
    n = (cfg.a[5:3] > 3'h6) ? 3'h6 : cfg.a[5:3];
    if (s < 2) return cfg.a[2];
    if (s < 5) return cfg.a[1];
    if (s == 5) return cfg.a[1] & ~tw;
    if (s < 8) return cfg.a[0];
    if (s < 10) return cfg.c[2];
    if (s < 16) return (s - 10) < int'(n);
    if (s == 16) return cfg.a[6];
    if (s == 17) return cfg.a[7];
    if (s == 18) return cfg.b[0];
    if (s == 19) return cfg.d[3];
    if (s < 26) return cfg.b[s - 19];
    if (s < 28) return cfg.d[s - 26];
    if (s < 30) return cfg.c[s - 25];
    if (s == 30) return cfg.b[7];
    return cfg.d[2];
  endfunction : sig_en
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    cmp_count++;
    if ((got & m) !== (exp & m))
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // -------------------------------------------------------------------------
  // reference allocation and comparison
  // -------------------------------------------------------------------------
  task automatic check_all();
    int p, np;
    int al[32];
    logic [31:0] eo, ee, am, pe, m;
    np = lg ? 32 : 24;
    p = 0;
    eo = 32'h0;
    ee = 32'h0;
    am = 32'h0;
    pe = 32'hffff_ffff;
    m = lg ? 32'hffff_ffff : 32'h00ff_ffff;
    for (int q = 0; q < 32; q++) al[q] = -1;
    for (int s = 0; s < 32; s++)
    begin
      if (sig_en(s))
      begin
        while (p < np && an[p]) p++;
        if (p < np)
        begin
          al[p] = s;
          p++;
        end
      end
    end
    for (int q = 0; q < 32; q++)
    begin
      if (al[q] >= 0)
      begin
        ee[q] = poe[al[q]];
        eo[q] = pout[al[q]];
        am[q] = 1'b1;
        pe[al[q]] = pin_in[q];
      end
      else
      begin
        ee[q] = ~an[q] & ~lat[q];
        eo[q] = lat[q];
      end
    end
    chk(pin_oe, ee, m);
    chk(pin_out, eo, am);
    chk(pin_out, eo, m & ~am);
    chk(periph_in, pe, 32'hffff_ffff);
    chk(lower_rd, pin_in & ~an, m);
    if (lg)
    begin
      chk(upin_oe, ~ulat, 32'hffff_ffff);
      chk(upper_rd, upin_in, 32'hffff_ffff);
      chk(upin_out, ulat, 32'hffff_ffff);
    end
    else
    begin
      chk(upper_rd, 32'h0, 32'hffff_ffff);
      chk(upin_oe, 32'h0, 32'hffff_ffff);
    end
  endtask : check_all
  // clock enable low: pins and a write change, pin_out, lower_rd and periph_in must hold
  task automatic freeze();
    logic [31:0] h0, h1, h2;
    @(negedge clock_i);
    h0 = pin_out;
    h1 = lower_rd;
    h2 = periph_in;
    ce = 1'b0;
    xv = ~xv;
    xe = 32'hffff_ffff;
    bw = {1'b1, 3'h0, 8'h00};
    repeat (3) @(negedge clock_i);
    chk(pin_out, h0, 32'hffff_ffff);
    chk(lower_rd, h1, 32'hffff_ffff);
    chk(periph_in, h2, 32'hffff_ffff);
    bw.en = 1'b0;
    ce = 1'b1;
  endtask : freeze
  // one config step with a random byte and bit write, then settle past the syncs
  task automatic run(input logic [31:0] c, input logic t, input logic l,
                     input logic [31:0] a);
    logic [31:0] r;
    @(negedge clock_i);
    cfg = c;
    tw = t;
    lg = l;
    an = a;
    pout = rnd();
    poe = rnd();
    xv = rnd();
    xe = rnd();
    uxv = rnd();
    uxe = rnd();
    r = rnd();
    bw = {r[0], r[3:1], r[11:4]};
    bitw = {r[12], r[17:13], r[18]};
    if (bw.en && bw.port < 3'h4) lat[8 * bw.port +: 8] = bw.data;
    if (bw.en && bw.port > 3'h3) ulat[8 * (bw.port - 3'h4) +: 8] = bw.data;
    if (bitw.en) lat[bitw.idx] = bitw.val;
    @(negedge clock_i);
    bw.en = 1'b0;
    bitw.en = 1'b0;
    repeat (5) @(negedge clock_i);
    check_all();
  endtask : run
  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (6) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    repeat (5) @(negedge clock_i);
    check_all();
    run(32'h0000_0004, 1'b0, 1'b0, 32'h0);
    run(32'h0040_143d, 1'b0, 1'b1, 32'h0000_1c00);
    run(32'h0000_0002, 1'b0, 1'b1, 32'h0);
    run(32'h0000_0002, 1'b1, 1'b1, 32'h0);
    for (int i = 0; i < 32; i++) run(32'h1 << i, lf[0], lf[1], 32'h0);
    for (int k = 0; k < 8; k++) run({29'h0, k[2:0]} << 3 | 32'h1, 1'b0, 1'b1, 32'h0);
    for (int i = 0; i < 60; i++)
    begin
      run(rnd(), lf[2], lf[3], rnd() & rnd() & rnd());
      if (i[2:0] == 3'h0) freeze();
    end
    run(32'hffff_ffff, 1'b0, 1'b0, 32'h0);
    run(32'hffff_ffff, 1'b1, 1'b1, 32'h0f0f_0f0f);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
